// file: core/csie_regs.vh
// Constants for the stack and interrupt entry block.
`ifndef CSIE_REGS_VH
`define CSIE_REGS_VH
`define CSIE_SPL_ADDR 6'h3d
`define CSIE_SPH_ADDR 6'h3e
`define CSIE_PROCESSOR_STATUS_REGISTER_ADDR 6'h3f
`define CSIE_GIE_BIT 7
`define CSIE_SP_RESET 16'h08ff
`define CSIE_SP_HI_MASK 8'h0f
`define CSIE_NSRC 8
`define CSIE_BOOT_BASE 16'h1c00
`define CSIE_VEC_STEP 16'h0002
`define CSIE_ENTRY_CYC 3'h4
`define CSIE_WAKE_CYC 3'h4
`define CSIE_RETURN_FROM_INTERRUPT_CYC 3'h4
`define CSIE_ST_IDLE 3'h0
`define CSIE_ST_ENTRY 3'h1
`define CSIE_ST_RETURN_FROM_INTERRUPT 3'h2
`define CSIE_ST_WAKE 3'h3
`define CSIE_ST_RET 3'h4
`endif

// file: core/csie_sync.v
// Two-flop synchroniser for the external level and flag sources.
`timescale 1ns/100ps
module csie_sync (
  input wire ref_clk_i, // CPU clock.
  input wire resetn_i, // Asynchronous reset, active low.
  input wire [7:0] d_i, // Asynchronous inputs.
  output reg [7:0] q_o // Synchronised outputs.
);
  reg [7:0] meta_r;

  // The first stage feeds only the second stage.
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= 8'h00;
      q_o <= 8'h00;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// file: core/csie_prio.v
// Fixed priority picker: the lowest index wins.
`timescale 1ns/100ps
module csie_prio (
  input wire [7:0] req_i, // Pending and enabled requests.
  output reg any_o, // Any request present.
  output reg [2:0] idx_o // Index of the winner.
);
  integer k;

  // Scan downward so the lowest index is the last written.
  always @* begin
    any_o = 1'b0;
    idx_o = 3'h0;
    for (k = 7; k >= 0; k = k - 1) begin
      if (req_i[k]) begin
        any_o = 1'b1;
        idx_o = k[2:0];
      end
    end
  end
endmodule

// file: core/csie_core.v
// Stack pointer and interrupt entry and exit control of the CPU core.
`timescale 1ns/100ps
`include "csie_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - One-byte push lowers the stack pointer by one; pop raises it by one.
// - Calls and interrupt entry lower it by two; returns raise it by two.
// - Reset loads the last SRAM address; software relocates before use.
// - Pointer is two byte registers in I/O space, low and high.
// - A source is taken only with its enable and the global enable set.
// - Lowest vector address wins; reset first, then external request zero.
// - Vector select bit moves vectors to boot section; fuse moves reset.
// - Programmed boot lock bits suppress interrupts depending on the PC.
// - Taking an interrupt clears the global enable; handlers may re-enable.
// - Return from interrupt sets the global enable.
// - Vectoring clears the flag; writing one to a flag clears it.
// - Flags set while disabled are kept and later served by priority.
// - Level sources request only while their condition is present.
// - One main instruction runs after a return before the next interrupt.
// - Disable instruction blocks interrupts at once, same cycle included.
// - The instruction after enable runs before any pending interrupt.
// - Entry takes four cycles pushing the PC before the vector runs.
// - Interrupts wait until a multi-cycle instruction completes.
// - Wake from sleep adds four cycles to the response.
// - Return takes four cycles, pops two bytes and sets global enable.
// - The status register is neither saved nor restored.
// - Global enable is bit 7 of the status register, with set and clear.
module csie_core (
  input wire ref_clk_i, // CPU clock, 50 MHz.
  input wire resetn_i, // Asynchronous reset, active low.
  input wire io_we_i, // I/O write strobe.
  input wire io_re_i, // I/O read strobe.
  input wire [5:0] io_addr_i, // I/O address.
  input wire [7:0] io_wdata_i, // I/O write data.
  output reg [7:0] io_rdata_o, // I/O read data.
  input wire [7:0] processor_status_register_flags_i, // Low status bits from the ALU.
  input wire push_i, // One-byte push.
  input wire pop_i, // One-byte pop.
  input wire call_i, // Call, indirect_call or relative_call.
  input wire ret_i, // Subroutine return.
  input wire return_from_interrupt_i, // Interrupt return started.
  input wire sei_i, // Set global enable instruction.
  input wire cli_i, // Clear global enable instruction.
  input wire instr_done_i, // Last cycle of an instruction.
  input wire sleep_i, // Core is asleep.
  input wire [15:0] pc_i, // Current program counter.
  input wire [15:0] boot_start_i, // First word of the boot section.
  input wire vector_table_select_i, // Vectors at boot section start.
  input wire boot_reset_fuse_i, // Reset vector at boot section start.
  input wire app_boot_lock_bit_i, // Lock for application section.
  input wire boot_section_lock_bit_i, // Lock for boot section.
  input wire [7:0] src_evt_i, // Flag-type event pins.
  input wire [7:0] src_lvl_i, // Level-type condition pins.
  input wire [7:0] src_is_lvl_i, // One where a source is level type.
  input wire [7:0] src_en_i, // Individual enables.
  input wire [7:0] flag_clr_i, // Software write-one-to-clear of flags.
  output reg [7:0] flag_o, // Remembered flags.
  output wire [15:0] sp_o, // Stack pointer.
  output wire [15:0] reset_vec_o, // Reset vector address.
  output reg irq_take_o, // Interrupt accepted this cycle.
  output reg irq_busy_o, // Entry or return sequence running.
  output reg [15:0] irq_vec_o, // Vector address to fetch.
  output reg mem_we_o, // Stack write strobe.
  output reg [15:0] mem_addr_o, // Stack address.
  output reg [7:0] mem_wdata_o, // Stack write data.
  output reg [15:0] ret_pc_o, // Program counter sampled at the end of a return.
  output reg gie_o // Global interrupt enable.
);
  reg [15:0] sp_r;
  reg [15:0] sp_nxt;
  reg [2:0] st_r;
  reg [2:0] cnt_r;
  reg [2:0] sel_r;
  reg [15:0] pc_hold_r;
  reg sei_hold_r;
  reg return_from_interrupt_hold_r;
  reg [7:0] flag_nxt;
  wire [7:0] evt_s;
  wire [7:0] lvl_s;
  wire [7:0] pend;
  wire any;
  wire [2:0] win;
  wire lock_off;
  wire can_take;
  wire [15:0] vec_base;

  csie_sync u_sync_evt (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .d_i(src_evt_i),
    .q_o(evt_s)
  );

  csie_sync u_sync_lvl (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .d_i(src_lvl_i),
    .q_o(lvl_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request formation.

  // Level sources bypass the flag, so a vanished condition never fires.
  genvar g;
  generate
    for (g = 0; g < `CSIE_NSRC; g = g + 1) begin : g_src
      assign pend[g] = src_en_i[g] & (src_is_lvl_i[g] ? lvl_s[g] : flag_o[g]);
    end
  endgenerate

  csie_prio u_prio (
    .req_i(pend),
    .any_o(any),
    .idx_o(win)
  );

  // Locked code regions do not accept interrupts while executing inside them.
  // Both locks compare against the live program counter, so a handler that
  // jumps across the boundary changes its own eligibility at once.
  assign lock_off = (app_boot_lock_bit_i & (pc_i < boot_start_i)) |
    (boot_section_lock_bit_i & (pc_i >= boot_start_i));

  // CLI in the same cycle wins; SEI and RETURN_FROM_INTERRUPT each defer by one instruction.
  assign can_take = any & gie_o & ~cli_i & ~lock_off & instr_done_i & ~sei_hold_r &
    ~return_from_interrupt_hold_r & (st_r == `CSIE_ST_IDLE);

  assign vec_base = vector_table_select_i ? boot_start_i : 16'h0000;
  assign reset_vec_o = boot_reset_fuse_i ? boot_start_i : 16'h0000;
  assign sp_o = sp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a new event beats both hardware and software clears.
  // The hardware clear lands one cycle after the accept pulse, so an event
  // arriving during entry is remembered rather than lost.
  always @* begin
    flag_nxt = flag_o & ~flag_clr_i;
    if (irq_take_o) begin
      flag_nxt[sel_r] = 1'b0;
    end
    flag_nxt = flag_nxt | (evt_s & ~src_is_lvl_i);
  end

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_o <= 8'h00;
    end else begin
      flag_o <= flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer next value; register writes land after stack motion.
  // Applying the write last means software reads back what it wrote, save the upper four bits of the high byte, which are masked to zero,
  // even when a push or pop falls in the same cycle.
  always @* begin
    sp_nxt = sp_r;
    if (push_i) begin
      sp_nxt = sp_r - 16'h0001;
    end else if (pop_i) begin
      sp_nxt = sp_r + 16'h0001;
    end else if (call_i) begin
      sp_nxt = sp_r - 16'h0002;
    end else if (ret_i) begin
      sp_nxt = sp_r + 16'h0002;
    end
    if ((st_r == `CSIE_ST_ENTRY) && (cnt_r == 3'h1)) begin
      sp_nxt = sp_r - 16'h0002;
    end
    if ((st_r == `CSIE_ST_RETURN_FROM_INTERRUPT) && (cnt_r == 3'h1)) begin
      sp_nxt = sp_r + 16'h0002;
    end
    if (io_we_i && (io_addr_i == `CSIE_SPL_ADDR)) begin
      sp_nxt = {sp_nxt[15:8], io_wdata_i};
    end
    if (io_we_i && (io_addr_i == `CSIE_SPH_ADDR)) begin
      sp_nxt = {io_wdata_i & `CSIE_SP_HI_MASK, sp_nxt[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read: pointer bytes and status with the live enable bit.
  // The status register itself is never saved here; handlers push it.
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_re_i) begin
      case (io_addr_i)
        `CSIE_SPL_ADDR: io_rdata_o <= sp_r[7:0];
        `CSIE_SPH_ADDR: io_rdata_o <= sp_r[15:8];
        `CSIE_PROCESSOR_STATUS_REGISTER_ADDR: io_rdata_o <= {gie_o, processor_status_register_flags_i[6:0]};
        default: io_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry and return sequencer with stack traffic.
  // Entry: the accept edge loads the vector and raises busy, the next two edges
  // write the low and then the high return byte, one edge idles, and the last
  // edge moves the pointer down by two and drops busy.
  // A wake from sleep inserts its extra cycles before the first stack write.
  // Return only presents the two pop addresses; the sequencer loads the program
  // counter itself, so the popped bytes never pass through this block.
  // Limitation: pushes, pops and calls are not interlocked with a running
  // sequence, so the sequencer must hold them off while busy is high.
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sp_r <= `CSIE_SP_RESET;
      st_r <= `CSIE_ST_IDLE;
      cnt_r <= 3'h0;
      sel_r <= 3'h0;
      pc_hold_r <= 16'h0000;
      gie_o <= 1'b0;
      sei_hold_r <= 1'b0;
      return_from_interrupt_hold_r <= 1'b0;
      irq_take_o <= 1'b0;
      irq_busy_o <= 1'b0;
      irq_vec_o <= 16'h0000;
      mem_we_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 8'h00;
      ret_pc_o <= 16'h0000;
    end else begin
      sp_r <= sp_nxt;
      irq_take_o <= 1'b0;
      mem_we_o <= 1'b0;
      // Holds clear only once the following instruction has finished.
      if (instr_done_i) begin
        sei_hold_r <= 1'b0;
        return_from_interrupt_hold_r <= 1'b0;
      end
      if (cli_i) begin
        gie_o <= 1'b0;
      end else if (sei_i) begin
        gie_o <= 1'b1;
        sei_hold_r <= ~gie_o;
      end else if (io_we_i && (io_addr_i == `CSIE_PROCESSOR_STATUS_REGISTER_ADDR)) begin
        gie_o <= io_wdata_i[`CSIE_GIE_BIT];
      end
      case (st_r)
        `CSIE_ST_IDLE: begin
          if (return_from_interrupt_i) begin
            st_r <= `CSIE_ST_RETURN_FROM_INTERRUPT;
            cnt_r <= `CSIE_RETURN_FROM_INTERRUPT_CYC;
            irq_busy_o <= 1'b1;
          end else if (can_take) begin
            sel_r <= win;
            pc_hold_r <= pc_i;
            gie_o <= 1'b0;
            irq_busy_o <= 1'b1;
            irq_vec_o <= vec_base + ({13'h0000, win} + 16'h0001) * `CSIE_VEC_STEP;
            st_r <= sleep_i ? `CSIE_ST_WAKE : `CSIE_ST_ENTRY;
            cnt_r <= sleep_i ? `CSIE_WAKE_CYC : `CSIE_ENTRY_CYC;
          end
        end
        `CSIE_ST_WAKE: begin
          // Extra response cycles while the core comes out of sleep.
          cnt_r <= cnt_r - 3'h1;
          if (cnt_r == 3'h1) begin
            st_r <= `CSIE_ST_ENTRY;
            cnt_r <= `CSIE_ENTRY_CYC;
          end
        end
        `CSIE_ST_ENTRY: begin
          cnt_r <= cnt_r - 3'h1;
          if (cnt_r == 3'h4) begin
            irq_take_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_addr_o <= sp_r;
            mem_wdata_o <= pc_hold_r[7:0];
          end else if (cnt_r == 3'h3) begin
            mem_we_o <= 1'b1;
            mem_addr_o <= sp_r - 16'h0001;
            mem_wdata_o <= pc_hold_r[15:8];
          end else if (cnt_r == 3'h1) begin
            st_r <= `CSIE_ST_IDLE;
            irq_busy_o <= 1'b0;
          end
        end
        `CSIE_ST_RETURN_FROM_INTERRUPT: begin
          cnt_r <= cnt_r - 3'h1;
          if (cnt_r == 3'h4) begin
            mem_addr_o <= sp_r + 16'h0001;
          end else if (cnt_r == 3'h3) begin
            mem_addr_o <= sp_r + 16'h0002;
          end else if (cnt_r == 3'h1) begin
            st_r <= `CSIE_ST_IDLE;
            irq_busy_o <= 1'b0;
            gie_o <= 1'b1;
            return_from_interrupt_hold_r <= 1'b1;
            ret_pc_o <= pc_i;
          end
        end
        default: begin
          st_r <= `CSIE_ST_IDLE;
          irq_busy_o <= 1'b0;
        end
      endcase
    end
  end
endmodule

// file: bench/csie_seq_model.sv
// Instruction sequencer model that marks the last cycle of each instruction.
`timescale 1ns/100ps
module csie_seq_model (
  input wire ref_clk_i, // CPU clock.
  input wire resetn_i, // Asynchronous reset, active low.
  input wire slow_i, // One selects three-cycle instructions.
  output wire instr_done_o // Last cycle of an instruction.
);
  logic [1:0] cnt_r;
  // Slow mode stretches every instruction so that requests must wait for its end.
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 2'h0;
    end else if (!slow_i || cnt_r == 2'h2) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
  // A fast core ends an instruction every cycle.
  assign instr_done_o = !slow_i || cnt_r == 2'h2;
endmodule

// file: bench/csie_core_props.sv
// Concurrent checks on the ports of the stack and interrupt entry block.
`timescale 1ns/100ps
module csie_core_props (
  input wire ref_clk_i, // CPU clock.
  input wire resetn_i, // Reset, active low.
  input wire io_we_i, // I/O write strobe.
  input wire push_i, // One-byte push.
  input wire pop_i, // One-byte pop.
  input wire call_i, // Call.
  input wire ret_i, // Subroutine return.
  input wire return_from_interrupt_i, // Interrupt return.
  input wire cli_i, // Clear global enable.
  input wire instr_done_i, // Last cycle of an instruction.
  input wire sleep_i, // Core is asleep.
  input wire irq_take_o, // Interrupt accepted.
  input wire irq_busy_o, // Sequence running.
  input wire mem_we_o, // Stack write strobe.
  input wire [15:0] mem_addr_o, // Stack address.
  input wire [15:0] sp_o, // Stack pointer.
  input wire gie_o // Global enable.
);
  // Pointer steps are only judged when nothing else moves the pointer.
  wire quiet = !io_we_i && !irq_busy_o && !return_from_interrupt_i;
  wire [3:0] sop = {ret_i, call_i, pop_i, push_i};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////
  chk_push_dec:
  assert property (quiet && sop == 4'h1 |=> sp_o == $past(sp_o) - 16'h1)
    else $error("push did not lower the pointer by one");
  chk_pop_inc:
  assert property (quiet && sop == 4'h2 |=> sp_o == $past(sp_o) + 16'h1)
    else $error("pop did not raise the pointer by one");
  chk_call_dec:
  assert property (quiet && sop == 4'h4 |=> sp_o == $past(sp_o) - 16'h2)
    else $error("call did not lower the pointer by two");
  chk_entry_len:
  assert property (irq_take_o |-> irq_busy_o [*3] ##1 (!irq_busy_o && sp_o == $past(sp_o, 3) - 16'h2))
    else $error("entry length or pointer step wrong");
  chk_entry_push:
  assert property (irq_take_o |-> mem_we_o && mem_addr_o == sp_o ##1 mem_we_o && mem_addr_o == sp_o - 16'h1)
    else $error("return address bytes written to wrong places");
  chk_take_gie:
  assert property (irq_take_o |-> !gie_o)
    else $error("global enable still set during entry");
  chk_no_gie:
  assert property (!gie_o && quiet |=> !irq_busy_o)
    else $error("interrupt taken with global enable clear");
  chk_cli_block:
  assert property (cli_i && quiet |=> !irq_busy_o)
    else $error("interrupt taken alongside disable");
  chk_return_from_interrupt_len:
  assert property (return_from_interrupt_i && !irq_busy_o |=> irq_busy_o [*4] ##1 (!irq_busy_o && gie_o && sp_o == $past(sp_o, 5) + 16'h2))
    else $error("interrupt return length or effect wrong");
  chk_return_from_interrupt_gap:
  assert property ($fell(irq_busy_o) && gie_o |=> !irq_busy_o)
    else $error("interrupt served right after return");
  chk_take_boundary:
  assert property ($rose(irq_busy_o) && !$past(return_from_interrupt_i) |-> $past(instr_done_i))
    else $error("interrupt accepted inside an instruction");
  chk_entry_start:
  assert property ($rose(irq_busy_o) && !$past(sleep_i) && !$past(return_from_interrupt_i)
    |=> irq_take_o)
    else $error("awake entry did not start its stack writes at once");
  chk_wake_delay:
  assert property ($rose(irq_busy_o) && $past(sleep_i) && !$past(return_from_interrupt_i)
    |-> !irq_take_o [*5] ##1 irq_take_o)
    else $error("wake entry did not add four response cycles");
endmodule
bind csie_core csie_core_props CHK (.*);

// file: bench/csie_core_bench.sv
// Self-checking bench for the stack and interrupt entry block.
`timescale 1ns/100ps
module csie_core_bench;
  logic ref_clk_i = 1'b0, resetn_i = 1'b0, io_we = 1'b0, io_re = 1'b0, sei = 1'b0;
  logic cli = 1'b0, return_from_interrupt = 1'b0, vts = 1'b0, fuse = 1'b0, slow = 1'b0, slp = 1'b0;
  logic take_d = 1'b0;
  logic [3:0] sop = 4'h0;
  logic [5:0] addr = 6'h0;
  logic [7:0] wd = 8'h0, flags = 8'h0, evt = 8'h0, en = 8'h0, clr = 8'h0, r;
  logic [7:0] lvl = 8'h0, isl = 8'h0;
  logic [15:0] bst = 16'h1c00, s, pc = 16'h0;
  logic [15:0] expq[$];
  wire done, take, busy, mwe, gie;
  wire [7:0] rd, flg, mwd;
  wire [15:0] sp, rvec, vec, maddr, rpc;
  int n_errors = 0, n_tests = 0, seed = 76, i;
  int dl[4] = '{-1, 1, -2, 2};
  always #10 ref_clk_i = ~ref_clk_i;
  csie_seq_model SEQ (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .slow_i(slow),
    .instr_done_o(done));
  csie_core DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .io_we_i(io_we), .io_re_i(io_re),
    .io_addr_i(addr), .io_wdata_i(wd), .io_rdata_o(rd), .processor_status_register_flags_i(flags), .push_i(sop[0]),
    .pop_i(sop[1]), .call_i(sop[2]), .ret_i(sop[3]), .return_from_interrupt_i(return_from_interrupt),
    .sei_i(sei), .cli_i(cli), .instr_done_i(done), .sleep_i(slp), .pc_i(pc),
    .boot_start_i(bst), .vector_table_select_i(vts), .boot_reset_fuse_i(fuse),
    .app_boot_lock_bit_i(1'b0), .boot_section_lock_bit_i(1'b0), .src_evt_i(evt),
    .src_lvl_i(lvl), .src_is_lvl_i(isl), .src_en_i(en), .flag_clr_i(clr), .flag_o(flg),
    .sp_o(sp), .reset_vec_o(rvec), .irq_take_o(take), .irq_busy_o(busy), .irq_vec_o(vec),
    .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mwd), .ret_pc_o(rpc), .gie_o(gie));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [15:0] e, input [15:0] g, input string nm);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    $display("Comparisons %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One I/O cycle and one idle cycle, so a second call never re-raises a strobe at once.
  task io(input w, input [5:0] a, input [7:0] d);
    io_we = w;
    io_re = !w;
    addr = a;
    wd = d;
    @(negedge ref_clk_i);
    io_we = 1'b0;
    io_re = 1'b0;
    @(negedge ref_clk_i);
  endtask
  // Waits for an entry or return sequence to start and finish, with a bound.
  task wait_seq;
    logic seen;
    seen = 1'b0;
    for (int k = 0; k < 60; k++) begin
      @(negedge ref_clk_i);
      if (busy === 1'b1) seen = 1'b1;
      else if (seen) return;
    end
    chk(16'h0, 16'h1, "sequence_end");
  endtask
  // Every accepted interrupt is matched against the oldest expected vector and return bytes.
  always @(negedge ref_clk_i) begin
    if (take === 1'b1) chk(expq.size() ? expq.pop_front() : ~vec, vec, "vector");
    if (take === 1'b1) chk(pc[7:0], mwd, "push_low");
    if (take_d) chk(pc[15:8], mwd, "push_high");
    take_d <= (take === 1'b1);
  end
  initial begin
    flags = $random(seed);
    pc = $random(seed);
    repeat (2) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    chk(16'h08ff, sp, "sp_reset");
    chk(16'h0, gie, "gie_reset");
    chk(16'h0, rvec, "reset_vec_app");
    fuse = 1'b1;
    @(negedge ref_clk_i);
    chk(bst, rvec, "reset_vec");
    r = $random(seed);
    io(1'b1, 6'h3d, r);
    io(1'b1, 6'h3e, 8'hf5);
    chk({8'h05, r}, sp, "sp_write");
    io(1'b0, 6'h3d, 8'h00);
    chk(r, rd, "sp_low_read");
    io(1'b0, 6'h3f, 8'h00);
    chk({1'b0, flags[6:0]}, rd, "status_read");
    s = sp;
    // Push, pop, call and return each move the pointer by their own step.
    for (i = 0; i < 4; i++) begin
      sop = 4'h1 << i;
      @(negedge ref_clk_i);
      sop = 4'h0;
      s = s + 16'(dl[i]);
      chk(s, sp, "sp_step");
      @(negedge ref_clk_i);
    end
    en = 8'h0a;
    evt = 8'h0a;
    repeat (2) @(negedge ref_clk_i);
    evt = 8'h00;
    repeat (5) @(negedge ref_clk_i);
    chk(8'h0a, flg, "flags_kept");
    expq.push_back(16'h0004);
    sei = 1'b1;
    @(negedge ref_clk_i);
    sei = 1'b0;
    wait_seq();
    chk(s - 16'h2, sp, "sp_entry");
    chk(16'h0, gie, "gie_entry");
    chk(8'h08, flg, "flag_hw_clear");
    vts = 1'b1;
    slow = 1'b1;
    expq.push_back(bst + 16'h0008);
    return_from_interrupt = 1'b1;
    @(negedge ref_clk_i);
    return_from_interrupt = 1'b0;
    wait_seq();
    chk(s, sp, "sp_return");
    chk(16'h1, gie, "gie_return");
    chk(pc, rpc, "ret_pc");
    wait_seq();
    chk(8'h00, flg, "flag_second");
    // A remembered flag meets enable, one guarded instruction, then a disable in the take cycle.
    slow = 1'b0;
    evt = 8'h02;
    repeat (2) @(negedge ref_clk_i);
    evt = 8'h00;
    repeat (3) @(negedge ref_clk_i);
    sei = 1'b1;
    @(negedge ref_clk_i);
    sei = 1'b0;
    @(negedge ref_clk_i);
    cli = 1'b1;
    @(negedge ref_clk_i);
    cli = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    chk(16'h0, 16'(busy), "cli_same_cycle");
    chk(8'h02, flg, "flag_blocked");
    clr = 8'h02;
    @(negedge ref_clk_i);
    clr = 8'h00;
    @(negedge ref_clk_i);
    chk(8'h00, flg, "flag_sw_clear");
    // A level request that vanishes while disabled must never be served.
    en = 8'h0e;
    isl = 8'h04;
    lvl = 8'h04;
    repeat (2) @(negedge ref_clk_i);
    lvl = 8'h00;
    repeat (3) @(negedge ref_clk_i);
    sei = 1'b1;
    @(negedge ref_clk_i);
    sei = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk(16'h0, 16'(busy), "level_gone");
    // The same level source, now present, wakes the sleeping core.
    expq.push_back(bst + 16'h0006);
    slp = 1'b1;
    lvl = 8'h04;
    wait_seq();
    slp = 1'b0;
    lvl = 8'h00;
    chk(s - 16'h4, sp, "sp_wake_entry");
    chk(16'h0, 16'(expq.size()), "vectors_left");
    finish_test();
  end
  // Cuts a hang short; the sequence needs well under a few hundred cycles.
  initial begin
    #50000;
    chk(16'h0, 16'h1, "watchdog");
    finish_test();
  end
endmodule
